// ---- include/ccd_consts.svh ----
`ifndef CCD_CONSTS_SVH
`define CCD_CONSTS_SVH
// register indexes; byte address is four times the index
`define CCD_IDX_BYPASS 8'h01
`define CCD_IDX_OUTCTL 8'h38
`define CCD_IDX_EDGE_BASE 8'h40
`define CCD_IDX_SAMPLE 8'h44
`define CCD_IDX_CLP_BASE 8'h48
`define CCD_IDX_PBK_BASE 8'h4c
`define CCD_IDX_CLPMASK_BASE 8'h50
`define CCD_IDX_PBKMASK_BASE 8'h53
`define CCD_IDX_STATUS 8'h56
`define CCD_ADDR_MSB 9
`define CCD_ADDR_LSB 2
// field positions
`define CCD_BYPASS_BIT 1
`define CCD_PHASE_LSB 0
`define CCD_FIXED_BIT 8
`define CCD_DELAY_LSB 9
`define CCD_EDGE_RISE_LSB 0
`define CCD_EDGE_FALL_LSB 8
`define CCD_EDGE_POL_BIT 16
`define CCD_SAMP_REF_LSB 0
`define CCD_SAMP_DATA_LSB 8
`define CCD_TOGGLE_FIRST_LSB 0
`define CCD_TOGGLE_SECOND_LSB 16
`define CCD_START_POLARITY_BIT 31
`define CCD_MSTART_LSB 0
`define CCD_MEND_LSB 16
`define CCD_ST_LINE_LSB 0
`define CCD_ST_CLAMP_BIT 12
`define CCD_ST_PREBLANK_PULSE_BIT 13
`define CCD_ST_PIX_LSB 16
// writable bits and reset values
`define CCD_OUTCTL_WMASK 32'h0000_073f
`define CCD_OUTCTL_RST 32'h0000_0400
`define CCD_EDGE_WMASK 32'h0001_3f3f
`define CCD_SAMP_WMASK 32'h0000_3f3f
`define CCD_PAT_WMASK 32'h9fff_1fff
`define CCD_PAT_RST 32'h9fff_1fff
`define CCD_MASK_WMASK 32'h0fff_0fff
`define CCD_MASK_RST 32'h0fff_0fff
`define CCD_MASK_OFF 12'hfff
`define CCD_TOG_MAX 13'h1fff
`define CCD_LINE_MAX 12'hfff
// edge grid and timing
`define CCD_EDGES 48
`define CCD_HALF_EDGES 24
`define CCD_QUAD_EDGES 12
`define CCD_QUAD_OFF_MAX 4'hb
`define CCD_LATENCY 16
`define CCD_CLK_PERIOD_PS 25000
`define CCD_DLY_STEP_PS 4000
`define CCD_NUM_CH 4
`define CCD_NUM_MASK 3
`define CCD_PIX_BITS 12
`define CCD_VSEQ_SEL_BITS 2
`endif

// ---- include/ccd_pkg.sv ----
`include "ccd_consts.svh"
package ccd_pkg;
   typedef struct packed {
      logic valid;
      logic [`CCD_PIX_BITS-1:0] data;
   } ccd_pixel_type;
   typedef enum {CCD_CH_LAST, CCD_CH_FIRST, CCD_CH_THIRD, CCD_CH_RESET} ccd_channel_type;
endpackage

// ---- design/ccd_timing_core.sv ----
// Function
// RULE1: output phase field selects edge 0..47
// RULE2: default mode: clock tracks data phase
// RULE3: fixed mode: clock is delayed master copy
// RULE4: four clock-to-data delays, default 8 ns
// RULE5: pixel appears 16 cycles after sampling
// RULE6: polarity bit inverts last, odd, reset clocks
// RULE7: separate rise and fall edge per clock
// RULE8: second, fourth clocks invert first, third
// RULE9: reference and data sampling edge fields
// RULE10: six-bit edge is quadrant plus offset
// RULE11: period split into 48 edge positions
// RULE12: avoid phase within 12 data-sampling edges
// RULE13: phase best near reference sampling edge
// RULE14: bypass bit skips output phase latch
// RULE15: pulses from start polarity, two toggles
// RULE16: pattern per vertical sequence, selected sequence
// RULE17: toggle positions are 13-bit pixel positions
// RULE18: unused toggles written to 8191
// RULE19: masking suppresses pulse, settings kept
// RULE20: three clamp masking line areas
// RULE21: three preblank masking line areas
// RULE22: masks apply whatever sequence is active
// RULE23: 12-bit mask lines, 0xfff disables
// RULE24: mask compared to field line counter
// RULE25: toggle match against per-line pixel counter
// RULE26: masked line holds pulse inactive high
`timescale 1ns/1ps
`default_nettype none
`include "ccd_consts.svh"
module ccd_timing_core import ccd_pkg::*; #(
   parameter int NUM_VSEQ = 4,
   parameter int PIPE_DEPTH = `CCD_LATENCY,
   parameter int FIXED_CLK_DELAY = 4
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [`CCD_PIX_BITS-1:0] adcData,
   input wire logic adcValid,
   input wire logic lineStart,
   input wire logic fieldStart,
   input wire logic [`CCD_VSEQ_SEL_BITS-1:0] vseqSel,
   output ccd_pixel_type pixelOut,
   output logic [5:0] pixelDataEdge,
   output logic [47:0] pixelOutClock,
   output logic [47:0] lastHorizontalClock,
   output logic [47:0] horizontalClockFirst,
   output logic [47:0] horizontalClockSecond,
   output logic [47:0] horizontalClockThird,
   output logic [47:0] horizontalClockFourth,
   output logic [47:0] resetGateClock,
   output logic [5:0] referenceSamplingEdge,
   output logic [5:0] dataSamplingEdge,
   output logic darkClampPulse_n,
   output logic preblankPulse_n
);

   // quadrant plus offset to linear edge; offsets above 11 clamp to 11
   function automatic logic [5:0] edgeDecode(input logic [5:0] v);
      logic [3:0] off;
      off = (v[3:0] > `CCD_QUAD_OFF_MAX) ? `CCD_QUAD_OFF_MAX : v[3:0];
      return 6'({4'h0, v[5:4]} * 6'(`CCD_QUAD_EDGES) + {2'h0, off}); // RULE10 RULE11
   endfunction

   function automatic logic [5:0] edgeWrap(input logic [6:0] s);
      return (s >= 7'(`CCD_EDGES)) ? 6'(s - 7'(`CCD_EDGES)) : s[5:0]; // RULE11
   endfunction

   // high from rise edge up to (not incl.) fall edge, wrapping over the period
   function automatic logic [47:0] edgePattern(input logic [5:0] r, input logic [5:0] f);
      logic [47:0] p;
      p = 48'h0;
      for (int k = 0; k < `CCD_EDGES; k++) begin
         if (r <= f)
            p[k] = (6'(k) >= r) && (6'(k) < f);
         else
            p[k] = (6'(k) >= r) || (6'(k) < f);
      end
      return p;
   endfunction

   // delay code in 4 ns steps, rounded up to whole edges
   function automatic logic [5:0] delayEdges(input logic [1:0] code);
      int ps;
      int st;
      ps = int'(code) * `CCD_DLY_STEP_PS;
      st = (ps * `CCD_EDGES + `CCD_CLK_PERIOD_PS - 1) / `CCD_CLK_PERIOD_PS;
      return 6'(st);
   endfunction

   // ---------------- bus slave ----------------
   logic [31:0] outCtl_q;
   logic bypass_q;
   logic [31:0] edgeReg_q [`CCD_NUM_CH];
   logic [31:0] sampleReg_q;
   logic [31:0] clpPat_q [NUM_VSEQ];
   logic [31:0] pbkPat_q [NUM_VSEQ];
   logic [31:0] clpMask_q [`CCD_NUM_MASK];
   logic [31:0] pbkMask_q [`CCD_NUM_MASK];
   logic dphRead_q;
   logic rdDone_q;
   logic wrPend_q;
   logic [7:0] idx_q;
   logic [31:0] hrdata_q;
   logic [31:0] rdMux;
   logic [12:0] pixCnt_q;
   logic [11:0] lineCnt_q;
   logic clampOut_q;
   logic pblkOut_q;

   wire accept = hsel && htrans[1] && hready;
   wire [7:0] addrIdx = haddr[`CCD_ADDR_MSB:`CCD_ADDR_LSB];
   wire rdStall = dphRead_q && !rdDone_q;
   wire wrOutCtl = wrPend_q && (idx_q == `CCD_IDX_OUTCTL);
   wire wrBypass = wrPend_q && (idx_q == `CCD_IDX_BYPASS);
   wire wrSample = wrPend_q && (idx_q == `CCD_IDX_SAMPLE);

   assign hreadyout = !rdStall;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         dphRead_q <= 1'b0;
         rdDone_q <= 1'b0;
         wrPend_q <= 1'b0;
         idx_q <= 8'h00;
         hrdata_q <= 32'h0000_0000;
      end else begin
         wrPend_q <= accept && hwrite;
         rdDone_q <= rdStall;
         if (hready) begin
            dphRead_q <= accept && !hwrite;
            idx_q <= addrIdx;
         end
         if (rdStall)
            hrdata_q <= rdMux;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         outCtl_q <= `CCD_OUTCTL_RST; // RULE4
         bypass_q <= 1'b0;
         sampleReg_q <= 32'h0000_0000;
      end else begin
         if (wrOutCtl)
            outCtl_q <= hwdata & `CCD_OUTCTL_WMASK;
         if (wrBypass)
            bypass_q <= hwdata[`CCD_BYPASS_BIT];
         if (wrSample)
            sampleReg_q <= hwdata & `CCD_SAMP_WMASK;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `CCD_NUM_CH; gi++) begin : g_edgeReg
         wire wrEdge = wrPend_q && (idx_q == 8'(`CCD_IDX_EDGE_BASE + gi));
         always_ff @(posedge ref_clk) begin
            if (!rst_n)
               edgeReg_q[gi] <= 32'h0000_0000;
            else if (wrEdge)
               edgeReg_q[gi] <= hwdata & `CCD_EDGE_WMASK; // RULE7
         end
      end
      for (gi = 0; gi < NUM_VSEQ; gi++) begin : g_patReg
         wire wrClp = wrPend_q && (idx_q == 8'(`CCD_IDX_CLP_BASE + gi));
         wire wrPbk = wrPend_q && (idx_q == 8'(`CCD_IDX_PBK_BASE + gi));
         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               clpPat_q[gi] <= `CCD_PAT_RST;
               pbkPat_q[gi] <= `CCD_PAT_RST;
            end else begin
               if (wrClp)
                  clpPat_q[gi] <= hwdata & `CCD_PAT_WMASK; // RULE16
               if (wrPbk)
                  pbkPat_q[gi] <= hwdata & `CCD_PAT_WMASK; // RULE16
            end
         end
      end
      for (gi = 0; gi < `CCD_NUM_MASK; gi++) begin : g_maskReg
         wire wrClm = wrPend_q && (idx_q == 8'(`CCD_IDX_CLPMASK_BASE + gi));
         wire wrPbm = wrPend_q && (idx_q == 8'(`CCD_IDX_PBKMASK_BASE + gi));
         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               clpMask_q[gi] <= `CCD_MASK_RST; // RULE23
               pbkMask_q[gi] <= `CCD_MASK_RST; // RULE23
            end else begin
               if (wrClm)
                  clpMask_q[gi] <= hwdata & `CCD_MASK_WMASK;
               if (wrPbm)
                  pbkMask_q[gi] <= hwdata & `CCD_MASK_WMASK;
            end
         end
      end
   endgenerate

   always_comb begin
      rdMux = 32'h0000_0000;
      if (idx_q == `CCD_IDX_OUTCTL)
         rdMux = outCtl_q;
      if (idx_q == `CCD_IDX_BYPASS)
         rdMux[`CCD_BYPASS_BIT] = bypass_q;
      if (idx_q == `CCD_IDX_SAMPLE)
         rdMux = sampleReg_q;
      if (idx_q == `CCD_IDX_STATUS) begin
         rdMux[`CCD_ST_LINE_LSB +: 12] = lineCnt_q;
         rdMux[`CCD_ST_CLAMP_BIT] = clampOut_q;
         rdMux[`CCD_ST_PREBLANK_PULSE_BIT] = pblkOut_q;
         rdMux[`CCD_ST_PIX_LSB +: 13] = pixCnt_q;
      end
      for (int i = 0; i < `CCD_NUM_CH; i++) begin
         if (idx_q == 8'(`CCD_IDX_EDGE_BASE + i))
            rdMux = edgeReg_q[i];
      end
      for (int i = 0; i < NUM_VSEQ; i++) begin
         if (idx_q == 8'(`CCD_IDX_CLP_BASE + i))
            rdMux = clpPat_q[i];
         if (idx_q == 8'(`CCD_IDX_PBK_BASE + i))
            rdMux = pbkPat_q[i];
      end
      for (int i = 0; i < `CCD_NUM_MASK; i++) begin
         if (idx_q == 8'(`CCD_IDX_CLPMASK_BASE + i))
            rdMux = clpMask_q[i];
         if (idx_q == 8'(`CCD_IDX_PBKMASK_BASE + i))
            rdMux = pbkMask_q[i];
      end
   end

   // ---------------- pixel output path ----------------
   ccd_pixel_type pipe_q [PIPE_DEPTH];

   generate
      for (gi = 0; gi < PIPE_DEPTH; gi++) begin : g_pipe
         always_ff @(posedge ref_clk) begin
            if (!rst_n)
               pipe_q[gi] <= '0;
            else if (gi == 0)
               pipe_q[gi] <= '{valid: adcValid, data: adcData}; // RULE5
            else
               pipe_q[gi] <= pipe_q[(gi == 0) ? 0 : gi - 1]; // RULE5
         end
      end
   endgenerate

   assign pixelOut = pipe_q[PIPE_DEPTH-1];

   // software should keep the phase at or just after the reference edge and
   // clear of the 12 edges after the data edge; nothing here enforces it
   wire [5:0] phaseEdge = edgeDecode(outCtl_q[`CCD_PHASE_LSB +: 6]); // RULE1 RULE12 RULE13
   wire [5:0] todEdges = delayEdges(outCtl_q[`CCD_DELAY_LSB +: 2]); // RULE4
   wire fixedMode = outCtl_q[`CCD_FIXED_BIT];
   wire [5:0] dataEdgeD = bypass_q ? 6'h00 : phaseEdge; // RULE14
   wire [5:0] trackRise = edgeWrap(7'({1'b0, dataEdgeD}) + 7'(`CCD_EDGES) - {1'b0, todEdges}); // RULE2 RULE4
   wire [5:0] fixedRise = 6'(FIXED_CLK_DELAY % `CCD_EDGES);
   wire [5:0] clkRise = fixedMode ? fixedRise : trackRise; // RULE3
   wire [5:0] clkFall = edgeWrap(7'({1'b0, clkRise}) + 7'(`CCD_HALF_EDGES));

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pixelDataEdge <= 6'h00;
         pixelOutClock <= 48'h0;
      end else begin
         pixelDataEdge <= dataEdgeD; // RULE1
         pixelOutClock <= edgePattern(clkRise, clkFall); // RULE2 RULE3
      end
   end

   // ---------------- fast horizontal clocks ----------------
   logic [47:0] hPat_q [`CCD_NUM_CH];

   generate
      for (gi = 0; gi < `CCD_NUM_CH; gi++) begin : g_hclk
         wire [5:0] riseEdge = edgeDecode(edgeReg_q[gi][`CCD_EDGE_RISE_LSB +: 6]); // RULE7
         wire [5:0] fallEdge = edgeDecode(edgeReg_q[gi][`CCD_EDGE_FALL_LSB +: 6]); // RULE7
         wire invert = edgeReg_q[gi][`CCD_EDGE_POL_BIT];
         always_ff @(posedge ref_clk) begin
            if (!rst_n)
               hPat_q[gi] <= 48'h0;
            else
               hPat_q[gi] <= edgePattern(riseEdge, fallEdge) ^ {48{invert}}; // RULE6
         end
      end
   endgenerate

   assign lastHorizontalClock = hPat_q[CCD_CH_LAST];
   assign horizontalClockFirst = hPat_q[CCD_CH_FIRST];
   assign horizontalClockThird = hPat_q[CCD_CH_THIRD];
   assign resetGateClock = hPat_q[CCD_CH_RESET];

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         horizontalClockSecond <= 48'hffff_ffff_ffff;
         horizontalClockFourth <= 48'hffff_ffff_ffff;
         referenceSamplingEdge <= 6'h00;
         dataSamplingEdge <= 6'h00;
      end else begin
         horizontalClockSecond <= ~(edgePattern(g_hclk[1].riseEdge, g_hclk[1].fallEdge)
                                    ^ {48{g_hclk[1].invert}}); // RULE8
         horizontalClockFourth <= ~(edgePattern(g_hclk[2].riseEdge, g_hclk[2].fallEdge)
                                    ^ {48{g_hclk[2].invert}}); // RULE8
         referenceSamplingEdge <= edgeDecode(sampleReg_q[`CCD_SAMP_REF_LSB +: 6]); // RULE9
         dataSamplingEdge <= edgeDecode(sampleReg_q[`CCD_SAMP_DATA_LSB +: 6]); // RULE9
      end
   end

   // ---------------- clamp and preblank ----------------
   wire [`CCD_VSEQ_SEL_BITS-1:0] seqIdx = (int'(vseqSel) < NUM_VSEQ) ? vseqSel : '0;
   wire [31:0] clpSel = clpPat_q[seqIdx]; // RULE16 RULE22
   wire [31:0] pbkSel = pbkPat_q[seqIdx]; // RULE16
   wire clpHit = (pixCnt_q == clpSel[`CCD_TOGGLE_FIRST_LSB +: 13]) || (pixCnt_q == clpSel[`CCD_TOGGLE_SECOND_LSB +: 13]); // RULE17 RULE25
   wire pbkHit = (pixCnt_q == pbkSel[`CCD_TOGGLE_FIRST_LSB +: 13]) || (pixCnt_q == pbkSel[`CCD_TOGGLE_SECOND_LSB +: 13]); // RULE17 RULE25
   wire [`CCD_NUM_MASK-1:0] clpInArea;
   wire [`CCD_NUM_MASK-1:0] pbkInArea;
   // masks follow the line being entered, so its first pixel is covered too
   wire [11:0] lineCntD = fieldStart ? 12'h000
                          : (lineStart && lineCnt_q != `CCD_LINE_MAX) ? lineCnt_q + 12'h001 : lineCnt_q; // RULE24
   logic clpLevel_q;
   logic pbkLevel_q;

   generate
      for (gi = 0; gi < `CCD_NUM_MASK; gi++) begin : g_mask
         wire [11:0] cs = clpMask_q[gi][`CCD_MSTART_LSB +: 12];
         wire [11:0] ce = clpMask_q[gi][`CCD_MEND_LSB +: 12];
         wire [11:0] ps = pbkMask_q[gi][`CCD_MSTART_LSB +: 12];
         wire [11:0] pe = pbkMask_q[gi][`CCD_MEND_LSB +: 12];
         assign clpInArea[gi] = (cs != `CCD_MASK_OFF) && (ce != `CCD_MASK_OFF)
                                && (lineCntD >= cs) && (lineCntD <= ce); // RULE20 RULE23 RULE24
         assign pbkInArea[gi] = (ps != `CCD_MASK_OFF) && (pe != `CCD_MASK_OFF)
                                && (lineCntD >= ps) && (lineCntD <= pe); // RULE21 RULE23 RULE24
      end
   endgenerate

   wire clpMasked = |clpInArea; // RULE22
   wire pbkMasked = |pbkInArea; // RULE22
   wire clpLevelD = lineStart ? clpSel[`CCD_START_POLARITY_BIT] : (clpLevel_q ^ clpHit); // RULE15
   wire pbkLevelD = lineStart ? pbkSel[`CCD_START_POLARITY_BIT] : (pbkLevel_q ^ pbkHit); // RULE15

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pixCnt_q <= 13'h0000;
         lineCnt_q <= 12'h000;
      end else begin
         if (lineStart)
            pixCnt_q <= 13'h0000; // RULE25
         else if (pixCnt_q != `CCD_TOG_MAX)
            pixCnt_q <= pixCnt_q + 13'h0001;
         lineCnt_q <= lineCntD; // RULE24
      end
   end

   // pattern level keeps running under a mask so unmasked lines stay correct
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         clpLevel_q <= 1'b1;
         pbkLevel_q <= 1'b1;
         clampOut_q <= 1'b1;
         pblkOut_q <= 1'b1;
      end else begin
         clpLevel_q <= clpLevelD;
         pbkLevel_q <= pbkLevelD;
         clampOut_q <= clpMasked ? 1'b1 : clpLevelD; // RULE19 RULE26
         pblkOut_q <= pbkMasked ? 1'b1 : pbkLevelD; // RULE19 RULE26
      end
   end

   assign darkClampPulse_n = clampOut_q;
   assign preblankPulse_n = pblkOut_q;

endmodule
`default_nettype wire

// ---- tb/ccd_timing_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ccd_consts.svh"
module ccd_timing_chk import ccd_pkg::*; #(
   parameter int PIPE_DEPTH = 16
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [`CCD_PIX_BITS-1:0] adcData,
   input wire logic adcValid,
   input wire ccd_pixel_type pixelOut,
   input wire logic [5:0] pixelDataEdge,
   input wire logic [47:0] horizontalClockFirst,
   input wire logic [47:0] horizontalClockSecond,
   input wire logic [47:0] horizontalClockThird,
   input wire logic [47:0] horizontalClockFourth,
   input wire logic [5:0] referenceSamplingEdge,
   input wire logic [5:0] dataSamplingEdge
);
   logic [5:0] upCnt_q;
   logic [5:0] upCnt_d;
   wire logic taken = hsel && htrans[1] && hready;
   // cycles since reset release, so the pipeline check skips words from reset
   assign upCnt_d = (upCnt_q == 6'h3f) ? upCnt_q : upCnt_q + 6'h01;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) upCnt_q <= 6'h00;
      else upCnt_q <= upCnt_d;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   pix_latency_a: assert property (int'(upCnt_q) > PIPE_DEPTH |->
      pixelOut == $past({adcValid, adcData}, PIPE_DEPTH)) else $error("pixel word latency wrong");
   second_inv_a: assert property (horizontalClockSecond == ~horizontalClockFirst)
      else $error("second clock not inverse of first");
   fourth_inv_a: assert property (horizontalClockFourth == ~horizontalClockThird)
      else $error("fourth clock not inverse of third");
   samp_range_a: assert property (referenceSamplingEdge < 6'h30 && dataSamplingEdge < 6'h30)
      else $error("sampling edge out of grid");
   phase_range_a: assert property (pixelDataEdge < 6'h30)
      else $error("data edge out of grid");
   read_wait_a: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   write_nowait_a: assert property (taken && hwrite |=> hreadyout)
      else $error("write stalled");
   okay_resp_a: assert property (hresp == 1'b0)
      else $error("response not okay");
endmodule
bind ccd_timing_core ccd_timing_chk #(.PIPE_DEPTH(PIPE_DEPTH)) i_ccd_timing_chk (.ref_clk(ref_clk), .rst_n(rst_n),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .adcData(adcData), .adcValid(adcValid), .pixelOut(pixelOut), .pixelDataEdge(pixelDataEdge),
   .horizontalClockFirst(horizontalClockFirst), .horizontalClockSecond(horizontalClockSecond),
   .horizontalClockThird(horizontalClockThird), .horizontalClockFourth(horizontalClockFourth),
   .referenceSamplingEdge(referenceSamplingEdge), .dataSamplingEdge(dataSamplingEdge));
`default_nettype wire

// ---- tb/ccd_pix_sink.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccd_pix_sink import ccd_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire ccd_pixel_type pixelOut,
   output logic [11:0] lastData_q,
   output logic [15:0] nWords_q
);
   // image processor side: takes every valid word at the clock edge
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         lastData_q <= 12'h000;
         nWords_q <= 16'h0000;
      end else if (pixelOut.valid) begin
         lastData_q <= pixelOut.data;
         nWords_q <= nWords_q + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// ---- tb/ccd_output_phase_clamp_blank_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ccd_consts.svh"
module ccd_output_phase_clamp_blank_tb import ccd_pkg::*; ;
   localparam int FixedDly = 4;
   logic ref_clk, hreadyout, hresp, rdySmp, darkClampPulse_n, preblankPulse_n;
   logic rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, adcValid = 1'b0, lineStart = 1'b0, fieldStart = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   logic [31:0] hrdata, hrdSmp, rdv;
   logic [1:0] htrans = 2'h0, vseqSel = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [11:0] adcData = 12'h000, sinkData;
   logic [15:0] sinkCount;
   ccd_pixel_type pixelOut;
   logic [5:0] pixelDataEdge, referenceSamplingEdge, dataSamplingEdge;
   logic [47:0] pixelOutClock, lastHorizontalClock, horizontalClockFirst, horizontalClockSecond;
   logic [47:0] horizontalClockThird, horizontalClockFourth, resetGateClock, expv;
   logic [47:0] chanOut [4];
   int fails = 0, nTests = 0;
   // channel, rise code, fall code, polarity, expected rise edge, expected fall edge
   int rows [5][6] = '{'{0, 0, 11, 0, 0, 11}, '{1, 16, 43, 1, 12, 35}, '{2, 5, 59, 0, 5, 47},
      '{3, 27, 48, 1, 23, 36}, '{0, 15, 32, 0, 11, 24}};
   assign chanOut[0] = lastHorizontalClock;
   assign chanOut[1] = horizontalClockFirst;
   assign chanOut[2] = horizontalClockThird;
   assign chanOut[3] = resetGateClock;
   ccd_timing_core #(.FIXED_CLK_DELAY(FixedDly)) i_ccd_timing_core (.ref_clk(ref_clk), .rst_n(rst_n),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .adcData(adcData),
      .adcValid(adcValid), .lineStart(lineStart), .fieldStart(fieldStart), .vseqSel(vseqSel),
      .pixelOut(pixelOut), .pixelDataEdge(pixelDataEdge), .pixelOutClock(pixelOutClock),
      .lastHorizontalClock(lastHorizontalClock), .horizontalClockFirst(horizontalClockFirst),
      .horizontalClockSecond(horizontalClockSecond), .horizontalClockThird(horizontalClockThird),
      .horizontalClockFourth(horizontalClockFourth), .resetGateClock(resetGateClock),
      .referenceSamplingEdge(referenceSamplingEdge), .dataSamplingEdge(dataSamplingEdge),
      .darkClampPulse_n(darkClampPulse_n), .preblankPulse_n(preblankPulse_n));
   ccd_pix_sink i_ccd_pix_sink (.ref_clk(ref_clk), .rst_n(rst_n), .pixelOut(pixelOut),
      .lastData_q(sinkData), .nWords_q(sinkCount));
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // bus answers are settled by the falling edge, so this copy is what the next rising edge sees
   always @(negedge ref_clk) begin
      rdySmp <= hreadyout;
      hrdSmp <= hrdata;
   end
   task automatic test_done();
      $display("checks=%0d fails=%0d", nTests, fails);
      if (fails == 0 && nTests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk_v(input logic [47:0] got, input logic [47:0] exp);
      nTests++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_b(input logic got, input logic exp);
      chk_v({47'h0, got}, {47'h0, exp});
   endtask
   task automatic wait_rdy();
      int k;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (rdySmp !== 1'b1 && k < 20);
      if (rdySmp !== 1'b1) begin
         fails++;
         test_done();
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {22'h0, idx, 2'h0};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rdv = hrdSmp;
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
      ahb(1'b0, idx, 32'h0);
      chk_v({16'h0, rdv}, {16'h0, exp});
   endtask
   task automatic settle();
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   function automatic logic [47:0] pat(input int r, input int f, input logic p);
      logic [47:0] v;
      for (int k = 0; k < 48; k++) v[k] = (k >= r && k < f) ^ p;
      return v;
   endfunction
   function automatic logic [47:0] clkp(input int r);
      logic [47:0] v;
      for (int k = 0; k < 48; k++) v[k] = ((k - r + 48) % 48) < 24;
      return v;
   endfunction
   task automatic pix(input logic [11:0] d);
      int n0;
      n0 = sinkCount;
      @(posedge ref_clk);
      adcValid <= 1'b1;
      adcData <= d;
      @(posedge ref_clk);
      adcValid <= 1'b0;
      adcData <= ~d;
      repeat (15) @(posedge ref_clk);
      #1;
      chk_v(48'(pixelOut), {35'h0, 1'b1, d});
      @(posedge ref_clk);
      #1;
      chk_v({36'h0, sinkData}, {36'h0, d});
      chk_v(48'(sinkCount), 48'(n0 + 1));
   endtask
   // one line with the toggle pair 5 and 10 and a high start level; masked pulses stay high
   task automatic line(input logic cm, input logic pm);
      @(posedge ref_clk);
      lineStart <= 1'b1;
      @(posedge ref_clk);
      lineStart <= 1'b0;
      for (int n = 1; n < 15; n++) begin
         if (n > 1) @(posedge ref_clk);
         #1;
         chk_b(darkClampPulse_n, cm | !(n >= 7 && n < 12));
         chk_b(preblankPulse_n, pm | !(n >= 7 && n < 12));
      end
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      #1;
      chk_b(darkClampPulse_n, 1'b1);
      @(posedge ref_clk);
      rst_n <= 1'b1;
      rdc(`CCD_IDX_OUTCTL, `CCD_OUTCTL_RST);
      rdc(`CCD_IDX_CLPMASK_BASE, `CCD_MASK_RST);
      rdc(`CCD_IDX_PBK_BASE, `CCD_PAT_RST);
      ahb(1'b1, 8'h30, 32'hffff_ffff);
      rdc(8'h30, 32'h0);
      ahb(1'b1, `CCD_IDX_OUTCTL, 32'hffff_ffff);
      rdc(`CCD_IDX_OUTCTL, `CCD_OUTCTL_WMASK);
      foreach (rows[i]) begin
         ahb(1'b1, 8'h40 + 8'(rows[i][0]), 32'(rows[i][3]) << 16 | 32'(rows[i][2]) << 8 | 32'(rows[i][1]));
         ahb(1'b1, `CCD_IDX_SAMPLE, 32'(rows[i][2]) << 8 | 32'(rows[i][1]));
         settle();
         expv = pat(rows[i][4], rows[i][5], rows[i][3] != 0);
         chk_v(chanOut[rows[i][0]], expv);
         chk_v({42'h0, referenceSamplingEdge}, 48'(rows[i][4]));
         chk_v({42'h0, dataSamplingEdge}, 48'(rows[i][5]));
      end
      // reference edge 24, data edge 0: phase 30 sits clear of the inhibit span
      ahb(1'b1, `CCD_IDX_SAMPLE, 32'h0000_0020);
      for (int d = 0; d < 4; d++) begin
         ahb(1'b1, `CCD_IDX_OUTCTL, 32'(d) << 9 | 32'h26);
         settle();
         chk_v({42'h0, pixelDataEdge}, 48'h1e);
         chk_v(pixelOutClock, clkp((30 - d * 8 + 48) % 48));
      end
      ahb(1'b1, `CCD_IDX_OUTCTL, 32'h0000_052b);
      settle();
      chk_v({42'h0, pixelDataEdge}, 48'h23);
      chk_v(pixelOutClock, clkp(FixedDly));
      pix(12'h5a3);
      ahb(1'b1, `CCD_IDX_BYPASS, 32'h0000_0002);
      settle();
      chk_v({42'h0, pixelDataEdge}, 48'h0);
      pix(12'ha5c);
      ahb(1'b1, `CCD_IDX_BYPASS, 32'h0);
      ahb(1'b1, `CCD_IDX_CLP_BASE + 8'h01, 32'h800a_0005);
      ahb(1'b1, `CCD_IDX_PBK_BASE + 8'h01, 32'h800a_0005);
      ahb(1'b1, `CCD_IDX_CLP_BASE, 32'h9fff_1fff);
      ahb(1'b1, `CCD_IDX_PBK_BASE, 32'h9fff_1fff);
      ahb(1'b1, `CCD_IDX_CLPMASK_BASE + 8'h02, 32'h0002_0002);
      ahb(1'b1, `CCD_IDX_PBKMASK_BASE, 32'h0003_0003);
      vseqSel <= 2'h1;
      @(posedge ref_clk);
      fieldStart <= 1'b1;
      @(posedge ref_clk);
      fieldStart <= 1'b0;
      line(1'b0, 1'b0);
      line(1'b1, 1'b0);
      line(1'b0, 1'b1);
      line(1'b0, 1'b0);
      vseqSel <= 2'h0;
      line(1'b1, 1'b1);
      rdc(`CCD_IDX_CLP_BASE + 8'h01, 32'h800a_0005);
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      rdc(`CCD_IDX_CLP_BASE + 8'h01, `CCD_PAT_RST);
      rdc(`CCD_IDX_PBKMASK_BASE, `CCD_MASK_RST);
      test_done();
   end
endmodule
`default_nettype wire
